// ### design/sensor_support_config_defs.vh
// Constants for the support configuration register slice.
// Assumes inclusion by bare name from the design directory.
`ifndef SENSOR_SUPPORT_CONFIG_DEFS_VH
`define SENSOR_SUPPORT_CONFIG_DEFS_VH

// ==========================================
// Register addresses (9-bit serial address)
`define ADDR_SERIAL_DRIVER_BIAS 9'h044
`define ADDR_BIAS_SPARE_AFE_REF 9'h046
`define ADDR_PUMP_CONTROL       9'h048
`define ADDR_SPARE_BLOCK_WORD0  9'h050
`define ADDR_SPARE_BLOCK_WORD1  9'h051
`define ADDR_THERMAL_DIODE_CTRL 9'h060
`define ADDR_THERMAL_RESULT     9'h061
`define ADDR_SERIAL_LANE_POWER  9'h070
`define ADDR_DARK_LEVEL_CAL     9'h080
`define ADDR_DARK_CAL_ERROR     9'h089

// ==========================================
// Reset values
`define RST_SERIAL_DRIVER_BIAS  16'h0088
`define RST_BIAS_SPARE_AFE_REF  16'h8888
`define RST_PUMP_CONTROL        16'h1200
`define RST_SPARE_BLOCK_WORD0   16'h0000
`define RST_SPARE_BLOCK_WORD1   16'h8881
`define RST_THERMAL_DIODE_CTRL  16'h0000
`define RST_THERMAL_RESULT      8'h00
`define RST_SERIAL_LANE_POWER   16'h0000
`define RST_DARK_LEVEL_CAL      16'h4008

// ==========================================
// Field positions
`define PUMP_PD_EN_BIT          0
`define PUMP_FD_EN_BIT          1
`define PUMP_PD_TRIM            10:8
`define PUMP_FD_TRIM            14:12
`define TEMP_DIODE_EN_BIT       0
`define LANE_CLK_PWR_BIT        0
`define LANE_SYNC_PWR_BIT       1
`define LANE_DATA_PWR_BIT       2
`define DARK_TARGET             7:0
`define DARK_SAMPLES            10:8

// ==========================================
// Serial frame layout: 9 address bits, 1 write bit, 16 data bits
`define FRAME_HDR_BITS          5'd10
`define FRAME_LAST_BIT          5'd26
`define FRAME_CNT_W             5

`endif

// ### design/sensor_support_config_regs.v
// Support configuration register slice: bias, pump, thermal, lane power, dark level.
// Assumes a host driving the four-wire serial port slowly against clock_i,
// and a datapath that reports black samples and window ends on clock_i.
//
// Notes on behaviour
// - Pump word resets to 0x1200; bits 0 and 1 enable the two pumps.
// - Pump word holds trim fields 10:8 default 2 and 14:12 default 1.
// - Thermal diode enable at bit 0 resets off; 8-bit result reads zero after reset.
// - Lane power bits 0 clock and 1 sync are active-low power-downs, reset 0.
// - Bit 2 powers all four data lanes together, reset cleared.
// - Dark level word resets to 0x4008; bits 7:0 give the target black level.
// - Bits 10:8 select averaged black samples as two to that power.
// - Per-channel error flag when fewer black samples arrive than required.
`timescale 1ns/100ps
`include "sensor_support_config_defs.vh"
`default_nettype none

module sensor_support_config_regs #(
    parameter CHANNELS = 8,
    parameter CNT_W    = 8
) (
    // Clock and reset
    input  wire                clock_i,
    input  wire                rst_b_i,
    // Serial host port
    input  wire                spi_sck_i,
    input  wire                spi_cs_b_i,
    input  wire                spi_mosi_i,
    output reg                 spi_miso_o,
    output reg                 spi_miso_oe_b_o,
    // Analog control outputs
    output reg  [15:0]         serial_driver_bias_o,
    output reg  [15:0]         bias_spare_afe_ref_o,
    output reg  [15:0]         spare_block_word0_o,
    output reg  [15:0]         spare_block_word1_o,
    output reg                 pump_pd_enable_o,
    output reg                 pump_fd_enable_o,
    output reg  [2:0]          pump_pd_trim_o,
    output reg  [2:0]          pump_fd_trim_o,
    output reg                 thermal_diode_enable_o,
    output reg                 clock_lane_pwr_n_o,
    output reg                 sync_lane_pwr_n_o,
    output reg  [3:0]          data_lane_pwr_n_o,
    output reg  [7:0]          dark_target_o,
    output reg  [2:0]          dark_samples_o,
    output reg  [CHANNELS-1:0] dark_cal_error_o,
    // Thermal readout, asynchronous to clock_i
    input  wire [7:0]          thermal_code_i,
    // Datapath black sample reporting, on clock_i
    input  wire [CHANNELS-1:0] black_sample_i,
    input  wire                black_window_end_i
);

    // ==========================================
    // Input synchronisers
    reg  [2:0]          sck_sync_q;
    reg  [1:0]          cs_sync_q;
    reg  [1:0]          mosi_sync_q;
    reg  [7:0]          therm_meta_q;
    reg  [7:0]          therm_sync_q;
    reg  [7:0]          therm_hold_q;

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sck_sync_q   <= 3'h0;
            cs_sync_q    <= 2'h3;
            mosi_sync_q  <= 2'h0;
            therm_meta_q <= 8'h00;
            therm_sync_q <= 8'h00;
            therm_hold_q <= 8'h00;
        end else begin
            sck_sync_q   <= {sck_sync_q[1:0], spi_sck_i};
            cs_sync_q    <= {cs_sync_q[0], spi_cs_b_i};
            mosi_sync_q  <= {mosi_sync_q[0], spi_mosi_i};
            therm_meta_q <= thermal_code_i;
            therm_sync_q <= therm_meta_q;
            therm_hold_q <= therm_sync_q;
        end
    end

    // Edges compare the second and third stages, never the first
    wire sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
    wire sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
    wire cs_on    = ~cs_sync_q[1];

    // ==========================================
    // Register storage
    reg  [15:0]         pump_q;
    reg  [15:0]         therm_ctrl_q;
    reg  [7:0]          therm_result_q;
    reg  [15:0]         lane_pwr_q;
    reg  [15:0]         dark_cal_q;

    // ==========================================
    // Read decode, used at header end
    function [15:0] read_word;
        input [8:0] addr;
        begin
            case (addr)
                `ADDR_SERIAL_DRIVER_BIAS: read_word = serial_driver_bias_o;
                `ADDR_BIAS_SPARE_AFE_REF: read_word = bias_spare_afe_ref_o;
                `ADDR_PUMP_CONTROL:       read_word = pump_q;
                `ADDR_SPARE_BLOCK_WORD0:  read_word = spare_block_word0_o;
                `ADDR_SPARE_BLOCK_WORD1:  read_word = spare_block_word1_o;
                `ADDR_THERMAL_DIODE_CTRL: read_word = therm_ctrl_q;
                `ADDR_THERMAL_RESULT:     read_word = {8'h00, therm_result_q};
                `ADDR_SERIAL_LANE_POWER:  read_word = lane_pwr_q;
                `ADDR_DARK_LEVEL_CAL:     read_word = dark_cal_q;
                `ADDR_DARK_CAL_ERROR:     read_word = {{(16-CHANNELS){1'b0}}, dark_cal_error_o};
                default:                  read_word = 16'h0000;
            endcase
        end
    endfunction

    // ==========================================
    // Serial frame engine
    reg  [`FRAME_CNT_W-1:0] bit_cnt_q;
    reg  [25:0]             shift_in_q;
    reg  [15:0]             shift_out_q;
    reg                     is_read_q;

    wire [25:0] shift_in_d = {shift_in_q[24:0], mosi_sync_q[1]};
    wire [4:0]  bit_cnt_d  = bit_cnt_q + 5'd1;
    // Commit only on the 26th bit of a write frame; bits after it in a longer frame are ignored
    wire        commit     = cs_on & sck_rise & (bit_cnt_d == `FRAME_LAST_BIT) & ~is_read_q;
    wire [8:0]  wr_addr    = shift_in_d[25:17];
    wire [15:0] wr_data    = shift_in_d[15:0];
    wire [15:0] rd_word    = read_word(shift_in_d[9:1]);

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_cnt_q       <= 5'h00;
            shift_in_q      <= 26'h0000000;
            shift_out_q     <= 16'h0000;
            is_read_q       <= 1'b0;
            spi_miso_o      <= 1'b0;
            spi_miso_oe_b_o <= 1'b1;
        end else if (!cs_on) begin
            bit_cnt_q       <= 5'h00;
            is_read_q       <= 1'b0;
            spi_miso_oe_b_o <= 1'b1;
        end else if (sck_rise) begin
            if (bit_cnt_q != `FRAME_LAST_BIT) begin
                bit_cnt_q <= bit_cnt_d;
            end
            shift_in_q <= shift_in_d;
            if (bit_cnt_d == `FRAME_HDR_BITS && !shift_in_d[0]) begin
                // Read: first data bit appears before the next rising edge
                is_read_q       <= 1'b1;
                spi_miso_o      <= rd_word[15];
                shift_out_q     <= {rd_word[14:0], 1'b0};
                spi_miso_oe_b_o <= 1'b0;
            end
        end else if (sck_fall && is_read_q && bit_cnt_q > `FRAME_HDR_BITS
                     && bit_cnt_q < `FRAME_LAST_BIT) begin
            spi_miso_o  <= shift_out_q[15];
            shift_out_q <= {shift_out_q[14:0], 1'b0};
        end
    end

    // ==========================================
    // Writable registers
    // Reserved bits are stored as written; the host keeps them at default
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            serial_driver_bias_o <= `RST_SERIAL_DRIVER_BIAS;
            bias_spare_afe_ref_o <= `RST_BIAS_SPARE_AFE_REF;
            pump_q               <= `RST_PUMP_CONTROL;
            spare_block_word0_o  <= `RST_SPARE_BLOCK_WORD0;
            spare_block_word1_o  <= `RST_SPARE_BLOCK_WORD1;
            therm_ctrl_q         <= `RST_THERMAL_DIODE_CTRL;
            lane_pwr_q           <= `RST_SERIAL_LANE_POWER;
            dark_cal_q           <= `RST_DARK_LEVEL_CAL;
        end else if (commit) begin
            case (wr_addr)
                `ADDR_SERIAL_DRIVER_BIAS: serial_driver_bias_o <= wr_data;
                `ADDR_BIAS_SPARE_AFE_REF: bias_spare_afe_ref_o <= wr_data;
                `ADDR_PUMP_CONTROL:       pump_q               <= wr_data;
                `ADDR_SPARE_BLOCK_WORD0:  spare_block_word0_o  <= wr_data;
                `ADDR_SPARE_BLOCK_WORD1:  spare_block_word1_o  <= wr_data;
                `ADDR_THERMAL_DIODE_CTRL: therm_ctrl_q         <= wr_data;
                `ADDR_SERIAL_LANE_POWER:  lane_pwr_q           <= wr_data;
                `ADDR_DARK_LEVEL_CAL:     dark_cal_q           <= wr_data;
                default: ;
            endcase
        end
    end

    // ==========================================
    // Field outputs, registered one cycle after storage
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pump_pd_enable_o       <= 1'b0;
            pump_fd_enable_o       <= 1'b0;
            pump_pd_trim_o         <= 3'h2;
            pump_fd_trim_o         <= 3'h1;
            thermal_diode_enable_o <= 1'b0;
            clock_lane_pwr_n_o     <= 1'b0;
            sync_lane_pwr_n_o      <= 1'b0;
            data_lane_pwr_n_o      <= 4'h0;
            dark_target_o          <= 8'h08;
            dark_samples_o         <= 3'h0;
            therm_result_q         <= `RST_THERMAL_RESULT;
        end else begin
            pump_pd_enable_o       <= pump_q[`PUMP_PD_EN_BIT];
            pump_fd_enable_o       <= pump_q[`PUMP_FD_EN_BIT];
            pump_pd_trim_o         <= pump_q[`PUMP_PD_TRIM];
            pump_fd_trim_o         <= pump_q[`PUMP_FD_TRIM];
            thermal_diode_enable_o <= therm_ctrl_q[`TEMP_DIODE_EN_BIT];
            clock_lane_pwr_n_o     <= lane_pwr_q[`LANE_CLK_PWR_BIT];
            sync_lane_pwr_n_o      <= lane_pwr_q[`LANE_SYNC_PWR_BIT];
            data_lane_pwr_n_o      <= {4{lane_pwr_q[`LANE_DATA_PWR_BIT]}};
            dark_target_o          <= dark_cal_q[`DARK_TARGET];
            dark_samples_o         <= dark_cal_q[`DARK_SAMPLES];
            // Readout follows the diode only while it is enabled; holds otherwise
            // A code caught mid-change never lands: two synced samples must agree
            if (therm_ctrl_q[`TEMP_DIODE_EN_BIT] && (therm_sync_q == therm_hold_q)) begin
                therm_result_q <= therm_sync_q;
            end
        end
    end

    // ==========================================
    // Black sample counting per channel
    // Counters saturate, so a long window never wraps into a false error
    wire [CNT_W:0] need = {{CNT_W{1'b0}}, 1'b1} << dark_cal_q[`DARK_SAMPLES];
    reg  [CNT_W:0] black_cnt_q [0:CHANNELS-1];
    integer        ch;

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dark_cal_error_o <= {CHANNELS{1'b0}};
            for (ch = 0; ch < CHANNELS; ch = ch + 1) begin
                black_cnt_q[ch] <= {(CNT_W+1){1'b0}};
            end
        end else begin
            for (ch = 0; ch < CHANNELS; ch = ch + 1) begin
                if (black_window_end_i) begin
                    dark_cal_error_o[ch] <= (black_cnt_q[ch] < need);
                    black_cnt_q[ch]      <= {(CNT_W+1){1'b0}};
                end else if (black_sample_i[ch] && !black_cnt_q[ch][CNT_W]) begin
                    black_cnt_q[ch] <= black_cnt_q[ch] + {{CNT_W{1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### verif/sensor_support_config_assertions.sv
// Concurrent checks on the support register slice.
// Assumes it is bound to the design top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module sensor_support_config_checker #(
    parameter CHANNELS = 8
) (
    input wire logic                clock_i,
    input wire logic                rst_b_i,
    input wire logic                spi_sck_i,
    input wire logic                spi_cs_b_i,
    input wire logic                spi_miso_o,
    input wire logic                spi_miso_oe_b_o,
    input wire logic [2:0]          pump_pd_trim_o,
    input wire logic [7:0]          dark_target_o,
    input wire logic [3:0]          data_lane_pwr_n_o,
    input wire logic [CHANNELS-1:0] dark_cal_error_o,
    input wire logic                black_window_end_i
);
    // ==========================================
    // Cycles since chip select was last low; fields may only move near a frame
    logic [3:0] idle_q;
    logic [3:0] idle_d;
    assign idle_d = !spi_cs_b_i ? 4'h0 : ((idle_q == 4'hF) ? idle_q : idle_q + 4'h1);
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i)
            idle_q <= 4'h0;
        else
            idle_q <= idle_d;
    end
    // ==========================================
    // Properties
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    sequence frame_open;
        $fell(spi_cs_b_i);
    endsequence
    sequence header_quiet;
        spi_miso_oe_b_o [*8];
    endsequence
    a_lanes_together: assert property (data_lane_pwr_n_o == 4'h0 || data_lane_pwr_n_o == 4'hF)
        else $error("data lanes not switched together");
    a_fields_quiet: assert property (idle_q > 4'h8 |->
        $stable({pump_pd_trim_o, dark_target_o, data_lane_pwr_n_o}))
        else $error("field output moved with no frame");
    a_header_quiet: assert property (frame_open |-> header_quiet)
        else $error("read driver on during header");
    a_oe_in_frame: assert property (!spi_miso_oe_b_o |-> idle_q < 4'h6)
        else $error("read driver on outside a frame");
    a_oe_release: assert property ($rose(spi_cs_b_i) |-> ##[1:5] spi_miso_oe_b_o)
        else $error("read driver not released");
    a_miso_after_fall: assert property ($changed(spi_miso_o) && !spi_miso_oe_b_o
        && $past(!spi_miso_oe_b_o) |-> !$past(spi_sck_i, 2))
        else $error("read bit moved while clock high");
    a_miso_hold: assert property ($rose(spi_sck_i) && !spi_miso_oe_b_o |=> $stable(spi_miso_o) [*4])
        else $error("read bit moved after clock rise");
    a_error_hold: assert property ($changed(dark_cal_error_o) |-> $past(black_window_end_i))
        else $error("error flags moved off window end");
endmodule
bind sensor_support_config_regs sensor_support_config_checker #(.CHANNELS(CHANNELS)) i_checker (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .spi_sck_i(spi_sck_i), .spi_cs_b_i(spi_cs_b_i),
    .spi_miso_o(spi_miso_o), .spi_miso_oe_b_o(spi_miso_oe_b_o), .pump_pd_trim_o(pump_pd_trim_o),
    .dark_target_o(dark_target_o), .data_lane_pwr_n_o(data_lane_pwr_n_o),
    .dark_cal_error_o(dark_cal_error_o), .black_window_end_i(black_window_end_i));
`default_nettype wire

// ### verif/spi_host_model.sv
// Serial host model: one 26-bit frame per call, levels of five clocks.
// Assumes clock_i is the design clock; changes signals on its falling edge.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    input  wire logic clock_i,
    input  wire logic miso_i,
    input  wire logic miso_oe_b_i,
    output var  logic sck_o,
    output var  logic cs_b_o,
    output var  logic mosi_o
);
    initial begin
        sck_o = 1'b0;
        cs_b_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic frame(input logic [8:0] addr, input logic wr, input logic [15:0] wdata,
                         output logic [15:0] rdata);
        logic [25:0] bits;
        bits = {addr, wr, wdata};
        rdata = 16'h0000;
        cs_b_o = 1'b0;
        repeat (5) @(negedge clock_i);
        for (int i = 25; i >= 0; i--) begin
            mosi_o = bits[i];
            repeat (5) @(negedge clock_i);
            sck_o = 1'b1;
            // A released line is read as the inverse, never as a lucky match
            if (i < 16)
                rdata = {rdata[14:0], miso_oe_b_i ? ~miso_i : miso_i};
            repeat (5) @(negedge clock_i);
            sck_o = 1'b0;
        end
        cs_b_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (8) @(negedge clock_i);
    endtask
endmodule
`default_nettype wire

// ### verif/test_sensor_support_config_regs.sv
// Bench for the support register slice: serial reads and writes, dark windows.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module test_sensor_support_config_regs;
    logic clock_i, rst_b_i, sck, cs_b, mosi, miso, miso_oe_b, win_end;
    logic pd_en, fd_en, diode_en, clk_pwr_n, sync_pwr_n;
    logic [2:0] pd_trim, fd_trim, samples;
    logic [3:0] data_pwr_n;
    logic [7:0] target, err, black, thermal;
    logic [15:0] q, drv_bias, afe_ref, spare0, spare1;
    int fail_count = 0;
    int check_count = 0;
    logic [8:0] addr_t [9] = '{9'h044, 9'h046, 9'h048, 9'h050, 9'h051, 9'h060, 9'h061, 9'h070, 9'h080};
    logic [15:0] rst_t [9] = '{16'h0088, 16'h8888, 16'h1200, 16'h0000, 16'h8881, 16'h0000,
                               16'h0000, 16'h0000, 16'h4008};
    spi_host_model i_host (.clock_i(clock_i), .miso_i(miso), .miso_oe_b_i(miso_oe_b),
        .sck_o(sck), .cs_b_o(cs_b), .mosi_o(mosi));
    sensor_support_config_regs i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .spi_sck_i(sck),
        .spi_cs_b_i(cs_b), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_b_o(miso_oe_b),
        .serial_driver_bias_o(drv_bias), .bias_spare_afe_ref_o(afe_ref),
        .spare_block_word0_o(spare0), .spare_block_word1_o(spare1),
        .pump_pd_enable_o(pd_en), .pump_fd_enable_o(fd_en),
        .pump_pd_trim_o(pd_trim), .pump_fd_trim_o(fd_trim), .thermal_diode_enable_o(diode_en),
        .clock_lane_pwr_n_o(clk_pwr_n), .sync_lane_pwr_n_o(sync_pwr_n),
        .data_lane_pwr_n_o(data_pwr_n), .dark_target_o(target), .dark_samples_o(samples),
        .dark_cal_error_o(err), .thermal_code_i(thermal), .black_sample_i(black),
        .black_window_end_i(win_end));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        i_host.frame(a, 1'b1, d, q);
    endtask
    task automatic rdchk(input logic [8:0] a, input logic [15:0] exp);
        i_host.frame(a, 1'b0, 16'h0000, q);
        check(q, exp);
    endtask
    // One calibration window; the flag expectation comes from the sel argument
    task automatic window(input int sel, input int cnt [8]);
        logic [7:0] exp;
        for (int k = 0; k < 130; k++) begin
            for (int c = 0; c < 8; c++)
                black[c] = (cnt[c] > k);
            @(negedge clock_i);
        end
        black = 8'h00;
        win_end = 1'b1;
        @(negedge clock_i);
        win_end = 1'b0;
        repeat (2) @(negedge clock_i);
        for (int c = 0; c < 8; c++)
            exp[c] = (cnt[c] < (1 << sel));
        check({8'h00, err}, {8'h00, exp});
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Frames take some 300 clocks; the whole run stays far below this
    initial begin
        #400us;
        fail_count++;
        test_done();
    end
    initial begin
        rst_b_i = 1'b0;
        black = 8'h00;
        win_end = 1'b0;
        thermal = 8'h5A;
        repeat (8) @(negedge clock_i);
        rst_b_i = 1'b1;
        repeat (3) @(negedge clock_i);
        for (int i = 0; i < 9; i++)
            rdchk(addr_t[i], rst_t[i]);
        check({10'h000, fd_trim, pd_trim}, 16'h000A);
        check({5'h00, samples, target}, 16'h0008);
        check({10'h000, diode_en, fd_en, pd_en, data_pwr_n[0], clk_pwr_n, sync_pwr_n}, 16'h0000);
        check(drv_bias, 16'h0088);
        check(afe_ref, 16'h8888);
        check(spare0, 16'h0000);
        check(spare1, 16'h8881);
        wr(9'h044, 16'h0057);
        check(drv_bias, 16'h0057);
        rdchk(9'h044, 16'h0057);
        wr(9'h048, 16'h5703);
        check({8'h00, fd_en, pd_en, fd_trim, pd_trim}, 16'h00EF);
        wr(9'h048, 16'h1201);
        check({14'h0000, fd_en, pd_en}, 16'h0001);
        wr(9'h070, 16'h0003);
        check({10'h000, data_pwr_n, sync_pwr_n, clk_pwr_n}, 16'h0003);
        wr(9'h070, 16'h0004);
        check({10'h000, data_pwr_n, sync_pwr_n, clk_pwr_n}, 16'h003C);
        wr(9'h060, 16'h0001);
        check({15'h0000, diode_en}, 16'h0001);
        rdchk(9'h061, 16'h005A);
        wr(9'h061, 16'h00FF);
        rdchk(9'h061, 16'h005A);
        wr(9'h0F0, 16'hFFFF);
        rdchk(9'h0F0, 16'h0000);
        wr(9'h080, 16'h4233);
        check({5'h00, samples, target}, 16'h0233);
        window(2, '{3, 4, 5, 0, 0, 0, 0, 0});
        wr(9'h080, 16'h4708);
        window(7, '{128, 127, 0, 0, 0, 0, 0, 0});
        wr(9'h080, 16'h4008);
        window(0, '{1, 0, 2, 0, 0, 0, 0, 0});
        rdchk(9'h089, 16'h00FA);
        test_done();
    end
endmodule
`default_nettype wire
